/* File: verilog/opad_regs.vh */
// Constants shared by the operand addressing decoder.
`ifndef OPAD_REGS_VH
`define OPAD_REGS_VH

// Status word location on the register port and its reset value.
`define OPAD_STATUS_ADDR      8'hD5
`define OPAD_STATUS_RST       8'h00
`define OPAD_BANK_BIT         0

// Operand form codes presented on dec_mode.
`define OPAD_M_WREG           4'h0
`define OPAD_M_WBIT           4'h1
`define OPAD_M_GREG           4'h2
`define OPAD_M_PAIR           4'h3
`define OPAD_M_IND_WPAIR      4'h4
`define OPAD_M_IND_ADDR       4'h5
`define OPAD_M_REG_INDEXED    4'h6
`define OPAD_M_SHORT_INDEXED  4'h7
`define OPAD_M_LONG_INDEXED   4'h8
`define OPAD_M_DIRECT_TARGET  4'h9
`define OPAD_M_RELATIVE       4'hA
`define OPAD_M_IMM            4'hB
`define OPAD_M_IMM_LONG       4'hC

// Result kinds reported on res_kind.
`define OPAD_K_WORK_REG       2'h0
`define OPAD_K_REG_ADDR       2'h1
`define OPAD_K_MEM_ADDR       2'h2
`define OPAD_K_DATA           2'h3

// Field positions inside the register select byte.
`define OPAD_IDX_MSB          3
`define OPAD_BIT_MSB          6
`define OPAD_BIT_LSB          4
`define OPAD_ODD_BIT          0

// Sign position of a byte displacement and its extension width.
`define OPAD_DISP_MSB         7
`define OPAD_DISP_EXT         8

// Zero helpers at the widths they meet.
`define OPAD_ZERO3            3'h0
`define OPAD_ZERO8            8'h00
`define OPAD_ZERO16           16'h0000

`endif

/* File: verilog/opad_decode.v */
// Operand addressing decoder with the bank select status word.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
//
// Contract
// - status bit 0 picks bank; ops clear/set it
// - working register 4-bit index, bit 3-bit position
// - general register: 8-bit address or working index
// - register pair operands must be even numbered
// - indirect working pair points to target location
// - indirect address form accepts even 0..254 only
// - indexed: 8-bit base plus working register contents
// - short indexed adds signed 8-bit to pair
// - long indexed adds unsigned 16-bit to pair
// - direct form carries full 16-bit target address
// - relative adds signed 8-bit to next address
// - immediate supplies 8-bit constant from stream
// - long immediate supplies 16-bit constant from stream
`include "opad_regs.vh"

module opad_decode #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    // Clock, reset and the freeze enable.
    sys_clk,
    sys_rst,
    clk_en,
    // Software register port.
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    // Bank instructions and the flag they drive.
    select_bank_zero_op,
    select_bank_one_op,
    bank_sel,
    // Decode request from the instruction stream.
    dec_valid,
    dec_mode,
    dec_wform,
    dec_sel,
    dec_word,
    next_pc,
    // Lookups into the working register file.
    wreg_idx,
    wpair_idx,
    wreg_data,
    wpair_data,
    // Resolved operand.
    res_valid,
    res_kind,
    res_addr,
    res_bit,
    res_err
);
    // Clock, reset and the freeze enable.
    input  wire              sys_clk;
    input  wire              sys_rst;
    input  wire              clk_en;

    // Software register port.
    input  wire [ADDR_W-1:0] reg_addr;
    input  wire [DATA_W-1:0] reg_wdata;
    input  wire              reg_wr;
    input  wire              reg_rd;
    output reg  [DATA_W-1:0] reg_rdata;

    // Bank instructions and the flag they drive.
    input  wire              select_bank_zero_op;
    input  wire              select_bank_one_op;
    output wire              bank_sel;

    // Decode request from the instruction stream.
    input  wire              dec_valid;
    input  wire [3:0]        dec_mode;
    input  wire              dec_wform;
    input  wire [7:0]        dec_sel;
    input  wire [15:0]       dec_word;
    input  wire [15:0]       next_pc;

    // Lookups into the working register file.
    output wire [3:0]        wreg_idx;
    output wire [3:0]        wpair_idx;
    input  wire [7:0]        wreg_data;
    input  wire [15:0]       wpair_data;

    // Resolved operand.
    output reg               res_valid;
    output reg  [1:0]        res_kind;
    output reg  [15:0]       res_addr;
    output reg  [2:0]        res_bit;
    output reg               res_err;

    ////////////////////////////////////////////////////////////////////
    // Status word.
    //
    // Only bit 0 has a meaning of its own inside this block: it picks
    // which bank of the upper register area the core addresses. The
    // other seven bits are plain storage here; the arithmetic flags
    // kept in them belong to the execution unit, outside this block.
    // The reset value is a choice, not a fixed figure.

    reg  [DATA_W-1:0] status_r;
    reg  [DATA_W-1:0] status_nxt;
    wire              status_hit;

    assign status_hit = (reg_addr == `OPAD_STATUS_ADDR);

    // Software write first, bank instructions after, so an instruction
    // in the same cycle as a store still lands; the set op beats the
    // clear op because both at once is a fetch fault we must not hide.
    // A store to any other address leaves the word alone; the port
    // decodes one location only.
    always @* begin
        status_nxt = status_r;
        if (reg_wr && status_hit) begin
            status_nxt = reg_wdata;
        end
        if (select_bank_zero_op) begin
            status_nxt[`OPAD_BANK_BIT] = 1'b0;
        end
        if (select_bank_one_op) begin
            status_nxt[`OPAD_BANK_BIT] = 1'b1;
        end
    end

    // Status register.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= `OPAD_STATUS_RST;
        end else if (clk_en) begin
            status_r <= status_nxt;
        end
    end

    // One-cycle-late read port. The data stand for one cycle only and
    // fall back to zero, so a stale read can never pass for a fresh
    // one at a master that samples late.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `OPAD_ZERO8;
        end else if (clk_en) begin
            if (reg_rd && status_hit) begin
                reg_rdata <= status_r;
            end else begin
                reg_rdata <= `OPAD_ZERO8; // Unmapped reads give zero.
            end
        end
    end

    // The flag steers the bank mux of the register file directly, so
    // a bank instruction counts from the very next instruction on.
    // bank select out.
    assign bank_sel = status_r[`OPAD_BANK_BIT];

    ////////////////////////////////////////////////////////////////////
    // Register file lookups.

    // The register file answers these in the same cycle, so the index
    // fields go out unregistered; they are only addresses, not results.
    // A lookup is made every cycle, request or not, so the file must
    // tolerate idle reads; a read has no side effect there, so this
    // costs nothing but power.
    // working register index.
    assign wreg_idx  = (dec_mode == `OPAD_M_REG_INDEXED) ?
                       dec_word[`OPAD_IDX_MSB:0] :
                       dec_sel[`OPAD_IDX_MSB:0];
    assign wpair_idx = dec_sel[`OPAD_IDX_MSB:0];

    ////////////////////////////////////////////////////////////////////
    // Operand resolution.
    //
    // Each form reduces to one 16-bit value and a kind, so the
    // consumer needs a single port instead of one per form. All sums
    // wrap: a register address wraps in 8 bits, a memory address in 16.
    // Odd pairs and pointers are flagged on res_err rather than
    // rounded down, because fixing them quietly would hide a bad
    // opcode from the core's fault logic.

    // Next values of the result fields.
    reg  [1:0]  kind_nxt;
    reg  [15:0] addr_nxt;
    reg  [2:0]  bit_nxt;
    reg         err_nxt;

    // Helpers shared by several forms.
    wire        sel_odd;
    wire [15:0] short_disp;
    wire [15:0] rel_disp;
    wire [7:0]  indexed_sum;

    // An odd low bit marks a pair or pointer that is not allowed.
    assign sel_odd     = dec_sel[`OPAD_ODD_BIT];
    assign short_disp  = {{`OPAD_DISP_EXT{dec_word[`OPAD_DISP_MSB]}},
                          dec_word[`OPAD_DISP_MSB:0]};
    assign rel_disp    = short_disp;
    assign indexed_sum = dec_sel + wreg_data;

    // One form per cycle; unknown codes report an error and address 0.
    // The defaults cover every field that a form leaves unused.
    always @* begin
        kind_nxt = `OPAD_K_REG_ADDR;
        addr_nxt = `OPAD_ZERO16;
        bit_nxt  = `OPAD_ZERO3;
        err_nxt  = 1'b0;
        case (dec_mode)
            // Sixteen working registers, named by a 4-bit index.
            // working register form.
            `OPAD_M_WREG: begin
                kind_nxt = `OPAD_K_WORK_REG;
                addr_nxt = {12'h000, dec_sel[`OPAD_IDX_MSB:0]};
            end

            // Same index, plus one of eight bit positions.
            // bit of working.
            `OPAD_M_WBIT: begin
                kind_nxt = `OPAD_K_WORK_REG;
                addr_nxt = {12'h000, dec_sel[`OPAD_IDX_MSB:0]};
                bit_nxt  = dec_sel[`OPAD_BIT_MSB:`OPAD_BIT_LSB];
            end

            // Either a full 256-location address or a working index.
            // general register form.
            `OPAD_M_GREG: begin
                if (dec_wform) begin
                    kind_nxt = `OPAD_K_WORK_REG;
                    addr_nxt = {12'h000, dec_sel[`OPAD_IDX_MSB:0]};
                end else begin
                    addr_nxt = {`OPAD_ZERO8, dec_sel};
                end
            end

            // Pairs start on an even register; odd ones are flagged.
            // even pairs only.
            `OPAD_M_PAIR: begin
                err_nxt = sel_odd;
                if (dec_wform) begin
                    kind_nxt = `OPAD_K_WORK_REG;
                    addr_nxt = {12'h000, dec_sel[`OPAD_IDX_MSB:0]};
                end else begin
                    addr_nxt = {`OPAD_ZERO8, dec_sel};
                end
            end

            // The pair's 16-bit contents are the target location.
            // pair as pointer.
            `OPAD_M_IND_WPAIR: begin
                kind_nxt = `OPAD_K_MEM_ADDR;
                err_nxt  = sel_odd;
                addr_nxt = wpair_data;
            end

            // Indirect address byte: even values 0 to 254 only.
            // even address only.
            `OPAD_M_IND_ADDR: begin
                err_nxt  = sel_odd;
                addr_nxt = {`OPAD_ZERO8, dec_sel};
            end

            // Base byte plus a working register, wrapping in 8 bits.
            // base plus register.
            `OPAD_M_REG_INDEXED: begin
                addr_nxt = {`OPAD_ZERO8, indexed_sum};
            end

            // Signed byte offset, -128 to +127, on a pair's contents.
            // signed short offset.
            `OPAD_M_SHORT_INDEXED: begin
                kind_nxt = `OPAD_K_MEM_ADDR;
                err_nxt  = sel_odd;
                addr_nxt = wpair_data + short_disp;
            end

            // Unsigned 16-bit offset on a pair's contents.
            // unsigned long offset.
            `OPAD_M_LONG_INDEXED: begin
                kind_nxt = `OPAD_K_MEM_ADDR;
                err_nxt  = sel_odd;
                addr_nxt = wpair_data + dec_word;
            end

            // The instruction carries the whole 16-bit target.
            // full direct target.
            `OPAD_M_DIRECT_TARGET: begin
                kind_nxt = `OPAD_K_MEM_ADDR;
                addr_nxt = dec_word;
            end

            // Signed byte offset from the following instruction.
            // next address relative.
            `OPAD_M_RELATIVE: begin
                kind_nxt = `OPAD_K_MEM_ADDR;
                addr_nxt = next_pc + rel_disp;
            end

            // A constant byte straight from the instruction stream.
            // byte immediate.
            `OPAD_M_IMM: begin
                kind_nxt = `OPAD_K_DATA;
                addr_nxt = {`OPAD_ZERO8, dec_word[7:0]};
            end

            // A constant word straight from the instruction stream.
            // word immediate.
            `OPAD_M_IMM_LONG: begin
                kind_nxt = `OPAD_K_DATA;
                addr_nxt = dec_word;
            end

            // Codes above the last form are not assigned.
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Result register.

    // Results hold until the next request; res_valid marks the fresh one.
    // Holding avoids a mux at the consumer, at the price of stale data
    // being visible while res_valid is low.
    // A request offered while clk_en is low is lost, not delayed: the
    // enable freezes the request capture along with everything else.
    // After reset the fields read as working register 0; res_valid
    // low marks that as meaningless.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_valid <= 1'b0;
            res_kind  <= `OPAD_K_WORK_REG;
            res_addr  <= `OPAD_ZERO16;
            res_bit   <= `OPAD_ZERO3;
            res_err   <= 1'b0;
        end else if (clk_en) begin
            res_valid <= dec_valid;
            if (dec_valid) begin
                res_kind <= kind_nxt;
                res_addr <= addr_nxt;
                res_bit  <= bit_nxt;
                res_err  <= err_nxt;
            end
        end
    end

endmodule

/* File: bench/opad_decode_monitor.sv */
// Checker tying decoder outputs to their causes at the ports.
`timescale 1ns/10ps
`include "opad_regs.vh"
module opad_decode_monitor (
    input wire        sys_clk,
    input wire        sys_rst,
    input wire        clk_en,
    input wire [7:0]  reg_addr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    input wire        select_bank_zero_op,
    input wire        select_bank_one_op,
    input wire        bank_sel,
    input wire        dec_valid,
    input wire [3:0]  dec_mode,
    input wire [7:0]  dec_sel,
    input wire [15:0] dec_word,
    input wire [15:0] next_pc,
    input wire [15:0] wpair_data,
    input wire        res_valid,
    input wire [15:0] res_addr,
    input wire [2:0]  res_bit,
    input wire        res_err
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Reference sums; the sign extension is where slips usually hide.
    wire        go    = dec_valid & clk_en;
    wire [15:0] sx    = {{8{dec_word[7]}}, dec_word[7:0]};
    wire [15:0] rel_t = next_pc + sx;
    wire [15:0] shx_t = wpair_data + sx;
    ////////////////////////////////////////
    property p_set; select_bank_one_op && clk_en |=> bank_sel; endproperty
    a_set: assert property (p_set) else $error("bank not set");
    property p_clr;
        select_bank_zero_op && !select_bank_one_op && clk_en |=> !bank_sel;
    endproperty
    a_clr: assert property (p_clr) else $error("bank not cleared");
    property p_stat; reg_rd && clk_en && reg_addr == `OPAD_STATUS_ADDR
        |=> reg_rdata[0] == $past(bank_sel); endproperty
    a_stat: assert property (p_stat) else $error("bank bit read");
    property p_wbit; go && dec_mode == `OPAD_M_WBIT |=> res_valid
        && res_bit == $past(dec_sel[6:4]) && res_addr == $past(dec_sel[3:0]);
    endproperty
    a_wbit: assert property (p_wbit) else $error("bit operand");
    property p_ind; go && dec_mode == `OPAD_M_IND_ADDR |=> res_valid
        && res_err == $past(dec_sel[0]) && res_addr == $past(dec_sel);
    endproperty
    a_ind: assert property (p_ind) else $error("indirect address");
    property p_short; go && dec_mode == `OPAD_M_SHORT_INDEXED
        |=> res_addr == $past(shx_t); endproperty
    a_short: assert property (p_short) else $error("short index");
    property p_rel; go && dec_mode == `OPAD_M_RELATIVE
        |=> res_addr == $past(rel_t); endproperty
    a_rel: assert property (p_rel) else $error("relative target");
    property p_imml; go && dec_mode == `OPAD_M_IMM_LONG
        |=> res_addr == $past(dec_word); endproperty
    a_imml: assert property (p_imml) else $error("long constant");
endmodule
bind opad_decode opad_decode_monitor u_opad_decode_monitor (.sys_clk,
    .sys_rst, .clk_en, .reg_addr, .reg_rd, .reg_rdata, .select_bank_zero_op,
    .select_bank_one_op, .bank_sel, .dec_valid, .dec_mode, .dec_sel,
    .dec_word, .next_pc, .wpair_data, .res_valid, .res_addr, .res_bit,
    .res_err);

/* File: bench/opad_regfile_model.sv */
// Working register file model answering the decoder's lookups.
`timescale 1ns/10ps
module opad_regfile_model (
    input  wire [3:0]  wreg_idx,
    input  wire [3:0]  wpair_idx,
    output wire [7:0]  wreg_data,
    output wire [15:0] wpair_data
);
    // Distinct contents so that an index slip changes every answer.
    reg [7:0] mem [0:15];
    integer   i;
    initial begin
        for (i = 0; i < 16; i = i + 1) begin
            mem[i] = 8'hA5 ^ (i * 8'h1B);
        end
    end
    // A pair reads its even register high and the next one low.
    assign wreg_data  = mem[wreg_idx];
    assign wpair_data = {mem[wpair_idx], mem[wpair_idx | 4'h1]};
endmodule

/* File: bench/tb_operand_addressing_decode.sv */
// Random and corner-case bench for the operand decoder.
`timescale 1ns/10ps
`include "opad_regs.vh"
module tb_operand_addressing_decode;
    reg         sys_clk, sys_rst, clk_en, reg_wr, reg_rd, dec_valid;
    reg         dec_wform, select_bank_zero_op, select_bank_one_op;
    reg  [7:0]  reg_addr, reg_wdata, dec_sel;
    reg  [3:0]  dec_mode;
    reg  [15:0] dec_word, next_pc;
    wire [7:0]  reg_rdata, wreg_data;
    wire [3:0]  wreg_idx, wpair_idx;
    wire [15:0] wpair_data, res_addr;
    wire [2:0]  res_bit;
    wire [1:0]  res_kind;
    wire        bank_sel, res_valid, res_err;
    integer     err_count, comparisons, seed, n;
    opad_decode u_opad_decode (.sys_clk, .sys_rst, .clk_en, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .select_bank_zero_op,
        .select_bank_one_op, .bank_sel, .dec_valid, .dec_mode, .dec_wform,
        .dec_sel, .dec_word, .next_pc, .wreg_idx, .wpair_idx, .wreg_data,
        .wpair_data, .res_valid, .res_kind, .res_addr, .res_bit, .res_err);
    opad_regfile_model u_opad_regfile_model (.wreg_idx, .wpair_idx,
        .wreg_data, .wpair_data);
    ////////////////////////////////////////
    // Expected {err, kind, bit, address} of one decode request.
    function [21:0] exp_res(input [3:0] m, input w, input [7:0] s,
                            input [15:0] d, input [15:0] pc);
        reg [15:0] pv, sx, ga;
        reg [1:0]  gk;
        begin
            pv = {u_opad_regfile_model.mem[s[3:0]],
                  u_opad_regfile_model.mem[s[3:0] | 4'h1]};
            sx = {{8{d[7]}}, d[7:0]};
            ga = w ? {12'h000, s[3:0]} : {8'h00, s};
            gk = w ? 2'h0 : 2'h1;
            case (m)
                `OPAD_M_WREG:          exp_res = {6'h00, 12'h000, s[3:0]};
                `OPAD_M_WBIT:    exp_res = {3'h0, s[6:4], 12'h000, s[3:0]};
                `OPAD_M_GREG:          exp_res = {1'b0, gk, 3'h0, ga};
                `OPAD_M_PAIR:          exp_res = {s[0], gk, 3'h0, ga};
                `OPAD_M_IND_WPAIR:     exp_res = {s[0], 5'h10, pv};
                `OPAD_M_IND_ADDR:      exp_res = {s[0], 13'h0800, s};
                `OPAD_M_REG_INDEXED:   exp_res = {14'h0800,
                    s + u_opad_regfile_model.mem[d[3:0]]};
                `OPAD_M_SHORT_INDEXED: exp_res = {s[0], 5'h10, pv + sx};
                `OPAD_M_LONG_INDEXED:  exp_res = {s[0], 5'h10, pv + d};
                `OPAD_M_DIRECT_TARGET: exp_res = {6'h10, d};
                `OPAD_M_RELATIVE:      exp_res = {6'h10, pc + sx};
                `OPAD_M_IMM:           exp_res = {14'h1800, d[7:0]};
                `OPAD_M_IMM_LONG:      exp_res = {6'h18, d};
                default: exp_res = {1'b1, `OPAD_K_REG_ADDR, 19'h00000};
            endcase
        end
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, e);
        end
    endtask
    task op(input one, input zero, input e);
        begin
            @(posedge sys_clk);
            select_bank_one_op <= one;
            select_bank_zero_op <= zero;
            @(posedge sys_clk);
            select_bank_one_op <= 1'b0;
            select_bank_zero_op <= 1'b0;
            #1 chk(bank_sel, e);
        end
    endtask
    // One request, checked while its res_valid pulse stands.
    task dec(input [3:0] m, input [7:0] s, input [15:0] d);
        reg [21:0] e, g;
        begin
            @(posedge sys_clk);
            dec_valid <= 1'b1;
            dec_mode <= m;
            dec_sel <= s;
            dec_word <= d;
            dec_wform <= $random(seed);
            next_pc <= $random(seed);
            @(posedge sys_clk);
            dec_valid <= 1'b0;
            e = exp_res(m, dec_wform, s, d, next_pc);
            #1 g = {res_err, res_kind, res_bit, res_addr};
            chk({res_valid, g}, {1'b1, e});
        end
    endtask
    task complete_run;
        begin
            $display("comparisons=%0d err_count=%0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #(40 * 3000);
        err_count = err_count + 1;
        complete_run;
    end
    initial begin
        {err_count, comparisons, seed} = {32'h0, 32'h0, 32'hDBE8};
        {sys_rst, clk_en, reg_wr, reg_rd, dec_valid, dec_wform} = 6'h30;
        {select_bank_zero_op, select_bank_one_op, dec_mode} = 6'h00;
        {reg_addr, reg_wdata, dec_sel, dec_word, next_pc} = 56'h0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`OPAD_STATUS_ADDR, 8'h00);
        op(1'b1, 1'b0, 1'b1);
        rd(`OPAD_STATUS_ADDR, 8'h01);
        op(1'b0, 1'b1, 1'b0);
        op(1'b1, 1'b1, 1'b1);
        op(1'b0, 1'b0, 1'b1);
        wr(`OPAD_STATUS_ADDR, 8'hA6);
        wr(8'hD4, 8'hFF);
        rd(8'hD4, 8'h00);
        rd(`OPAD_STATUS_ADDR, 8'hA6);
        chk(bank_sel, 1'b0);
        // A clear op beside a store wins bit 0; the rest take the store.
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, `OPAD_STATUS_ADDR, 8'h5B};
        select_bank_zero_op <= 1'b1;
        @(posedge sys_clk);
        {reg_wr, select_bank_zero_op} <= 2'b00;
        rd(`OPAD_STATUS_ADDR, 8'h5A);
        // With the enable low a set op must not reach the flag.
        @(posedge sys_clk);
        clk_en <= 1'b0;
        op(1'b1, 1'b0, 1'b0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        for (n = 0; n < 16; n = n + 1) begin
            dec(n[3:0], 8'hFF, 16'hFFFF);
            dec(n[3:0], 8'h0E, 16'h0080);
        end
        repeat (300) dec($random(seed), $random(seed), $random(seed));
        complete_run;
    end
endmodule
